// >>> drive_regs_consts.svh
/*
  Offsets, field positions, reset values and encodings of the drive state
  and error parameter bank.
  Assumes parameter numbers arrive as 16-bit addresses on the parameter port.
*/
`ifndef DRIVE_REGS_CONSTS_SVH
`define DRIVE_REGS_CONSTS_SVH

// parameter addresses
`define ADDR_FB_COUNT 16'h084C
`define ADDR_FB_WARN_LAT 16'h084D
`define ADDR_FB_WARN_LIVE 16'h084E
`define ADDR_FB_FAULT_LAT 16'h084F
`define ADDR_FB_FAULT_LIVE 16'h0850
`define ADDR_STO_COUNT 16'h0853
`define ADDR_STO_FAULT_LAT 16'h0854
`define ADDR_STO_FAULT_LIVE 16'h0855
`define ADDR_INT_COUNT 16'h088F
`define ADDR_INT_FAULT_LAT 16'h0890
`define ADDR_INT_FAULT_LIVE 16'h0891
`define ADDR_CMD 16'h0960
`define ADDR_STATUS 16'h0961
`define ADDR_QSEL 16'h0962

// constant entry counts
`define CNT_FB 8'h04
`define CNT_STO 8'h02
`define CNT_INT 8'h02

// reset values
`define RST_CMD 16'h0000
`define RST_QSEL 16'h0006
`define RST_DETAIL 16'h0000

// command word fields
`define CMD_FRST_BIT 7
`define CMD_HALT_BIT 8
`define CMD_MODE_LSB 4
`define CMD_MODE_MSB 6
`define CMD_GEAR_LSB 13
`define CMD_GEAR_MSB 15

// transition commands: mask and value on bits 0..3 and 7
`define CMD_SHUT_M 16'h0087
`define CMD_SHUT_V 16'h0006
`define CMD_SWON_M 16'h008F
`define CMD_SWON_V 16'h0007
`define CMD_ENOP_M 16'h008F
`define CMD_ENOP_V 16'h000F
`define CMD_DISV_M 16'h0082
`define CMD_DISV_V 16'h0000
`define CMD_QSTP_M 16'h0086
`define CMD_QSTP_V 16'h0002

// status word patterns, insignificant bits at zero
`define SW_NOT_READY 16'h0000
`define SW_DISABLED 16'h0040
`define SW_READY 16'h0021
`define SW_ON 16'h0023
`define SW_OP 16'h0027
`define SW_QSTOP 16'h0007
`define SW_FREACT 16'h000F
`define SW_FAULT 16'h0008

// quick stop reaction selector values
`define QS_MAX 16'hFFFF
`define QS_PROF_INT 16'hFFFB
`define QS_EMER_INT 16'hFFFA
`define QS_PROF_DIS 16'h0001
`define QS_EMER_DIS 16'h0002
`define QS_PROF_STAY 16'h0005
`define QS_EMER_STAY 16'h0006

`endif

// >>> drive_regs_pkg.sv
/*
  Types of the drive state and error parameter bank.
  Assumes nothing beyond the constants header.
*/
package drive_regs_pkg;

  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SW_DISABLED = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP_ENABLED = 8'h10,
    ST_QUICK_STOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_e;

  typedef struct packed {
    drive_state_e st;
    logic [15:0] cmd;
    logic [15:0] qsel;
    logic [15:0] status;
    logic [7:0] mode_tag;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic rst_pulse;
    logic braking;
    logic speed_zero;
    logic integ_clr;
    logic decel_sel;
    logic torque;
  } bank_s;

endpackage : drive_regs_pkg

// >>> err_detail.sv
/*
  One pair of error detail words: a latched copy and a live copy.
  Assumes cond is synchronous to mclk and clear is a one-cycle pulse.
*/
module err_detail
  import drive_regs_pkg::*;
#(
  parameter int W = 16
)(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // condition and clear
  input wire logic [W-1:0] cond,
  input wire logic clear,
  // detail words
  output logic [W-1:0] latched_q,
  output logic [W-1:0] live_q
);

  typedef struct packed {
    logic [W-1:0] lat;
    logic [W-1:0] live;
  } detail_s;

  detail_s s_q;
  detail_s s_d;

  always_comb
  begin
    s_d = s_q;
    // a condition present in the clearing cycle stays latched
    s_d.lat = (clear ? '0 : s_q.lat) | cond;
    s_d.live = cond;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign latched_q = s_q.lat;
  assign live_q = s_q.live;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  latch_holds_a: assert property ((cond != '0) |=> ((latched_q & $past(cond)) == $past(cond))) else $error("condition not latched");
  live_follows_a: assert property (1'b1 |=> live_q == $past(cond)) else $error("live word lags condition");

endmodule : err_detail

// >>> drive_state_error_registers.sv
/*
  Drive state and error parameter bank: error detail words, command word,
  status word with the drive state machine, quick stop reaction selector.
  Assumes a parameter master issues one-cycle requests on par_req and that
  motion control reports the end of a braking ramp on ramp_done.
*/
//
// Contract
// - feedback group: four read-only zero-reset words
// - constant entry counts: four, two, two
// - safe torque off: latched and live faults
// - internal group: latched and live faults
// - command bits 0-3,7 drive state transitions
// - command bit 8 requests halt
// - bits 4-6 per mode, 13-15 gear
// - status word reports state, significant bits only
// - not ready, disabled, ready encodings
// - switched on and operation enabled encodings
// - quick stop active encoding
// - fault reaction and fault encodings
// - selector -1: zero speed, then disabled
// - selector -5/-6: ramp, then clear integrator
// - selector 1/2: ramp, then disabled
// - selector 5/6: ramp, stay quick stop
// - standby select decides switched on torque
`include "drive_regs_consts.svh"

module drive_state_error_registers
  import drive_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // parameter access
  input wire logic par_req,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_ack,
  output logic par_err,
  // error conditions
  input wire logic [15:0] fb_warn_cond,
  input wire logic [15:0] fb_fault_cond,
  input wire logic [15:0] sto_fault_cond,
  input wire logic [15:0] int_fault_cond,
  // motion control inputs
  input wire logic ramp_done,
  input wire logic [7:0] active_operating_mode,
  input wire logic standby_torque_select,
  // motion control outputs
  output logic [15:0] status_word,
  output logic torque_enable,
  output logic halt_request,
  output logic [2:0] mode_cmd,
  output logic [7:0] mode_cmd_tag,
  output logic [2:0] gear_mode,
  output logic ramp_active,
  output logic decel_select,
  output logic speed_zero,
  output logic velocity_integral_clear,
  output logic fault_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // error detail words

  logic [3:0][15:0] cond_all;
  logic [3:0][15:0] lat_w;
  logic [3:0][15:0] live_w;
  logic any_fault;
  bank_s s_q;
  bank_s s_d;

  assign cond_all = {int_fault_cond, sto_fault_cond, fb_fault_cond,
                     fb_warn_cond};
  assign any_fault = (|fb_fault_cond) | (|sto_fault_cond) | (|int_fault_cond);

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_detail
      err_detail #(
        .W(16)
      ) u_detail (
        .mclk(mclk),
        .resetn(resetn),
        .cond(cond_all[g]),
        .clear(s_q.rst_pulse),
        .latched_q(lat_w[g]),
        .live_q(live_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic cmd_is(input logic [15:0] c, input logic [15:0] m,
                                  input logic [15:0] v);
    cmd_is = (c & m) == v;
  endfunction : cmd_is

  function automatic logic [15:0] state_code(input drive_state_e st);
    unique case (st)
      ST_NOT_READY: state_code = `SW_NOT_READY;
      ST_SW_DISABLED: state_code = `SW_DISABLED;
      ST_READY: state_code = `SW_READY;
      ST_SWITCHED_ON: state_code = `SW_ON;
      ST_OP_ENABLED: state_code = `SW_OP;
      ST_QUICK_STOP: state_code = `SW_QSTOP;
      ST_FAULT_REACT: state_code = `SW_FREACT;
      ST_FAULT: state_code = `SW_FAULT;
      default: state_code = `SW_NOT_READY;
    endcase
  endfunction : state_code

  function automatic logic qsel_legal(input logic [15:0] v);
    qsel_legal = (v == `QS_MAX) || (v == `QS_PROF_INT) ||
                 (v == `QS_EMER_INT) || (v == `QS_PROF_DIS) ||
                 (v == `QS_EMER_DIS) || (v == `QS_PROF_STAY) ||
                 (v == `QS_EMER_STAY);
  endfunction : qsel_legal

  // {hit, data}
  function automatic logic [16:0] read_word(input logic [15:0] a,
                                           input bank_s s);
    unique case (a)
      `ADDR_FB_COUNT: read_word = {1'b1, 8'h00, `CNT_FB};
      `ADDR_STO_COUNT: read_word = {1'b1, 8'h00, `CNT_STO};
      `ADDR_INT_COUNT: read_word = {1'b1, 8'h00, `CNT_INT};
      `ADDR_FB_WARN_LAT: read_word = {1'b1, lat_w[0]};
      `ADDR_FB_WARN_LIVE: read_word = {1'b1, live_w[0]};
      `ADDR_FB_FAULT_LAT: read_word = {1'b1, lat_w[1]};
      `ADDR_FB_FAULT_LIVE: read_word = {1'b1, live_w[1]};
      `ADDR_STO_FAULT_LAT: read_word = {1'b1, lat_w[2]};
      `ADDR_STO_FAULT_LIVE: read_word = {1'b1, live_w[2]};
      `ADDR_INT_FAULT_LAT: read_word = {1'b1, lat_w[3]};
      `ADDR_INT_FAULT_LIVE: read_word = {1'b1, live_w[3]};
      `ADDR_CMD: read_word = {1'b1, s.cmd};
      `ADDR_STATUS: read_word = {1'b1, s.status};
      `ADDR_QSEL: read_word = {1'b1, s.qsel};
      default: read_word = {1'b0, 16'h0000};
    endcase
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic c_shut;
  logic c_swon;
  logic c_enop;
  logic c_disv;
  logic c_qstp;
  logic qs_emer;
  logic qs_to_dis;

  assign c_shut = cmd_is(s_q.cmd, `CMD_SHUT_M, `CMD_SHUT_V);
  assign c_swon = cmd_is(s_q.cmd, `CMD_SWON_M, `CMD_SWON_V);
  assign c_enop = cmd_is(s_q.cmd, `CMD_ENOP_M, `CMD_ENOP_V);
  assign c_disv = cmd_is(s_q.cmd, `CMD_DISV_M, `CMD_DISV_V);
  assign c_qstp = cmd_is(s_q.cmd, `CMD_QSTP_M, `CMD_QSTP_V);
  assign qs_emer = (s_q.qsel == `QS_EMER_INT) || (s_q.qsel == `QS_EMER_DIS) ||
                   (s_q.qsel == `QS_EMER_STAY) || (s_q.qsel == `QS_MAX);
  assign qs_to_dis = (s_q.qsel == `QS_MAX) || (s_q.qsel == `QS_PROF_DIS) ||
                     (s_q.qsel == `QS_EMER_DIS);

  always_comb
  begin
    logic [16:0] rd;
    rd = read_word(par_addr, s_q);
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    s_d.rst_pulse = 1'b0;
    s_d.integ_clr = 1'b0;
    // parameter access, answered one cycle after the request
    if (par_req)
    begin
      s_d.ack = 1'b1;
      if (par_we)
      begin
        if (par_addr == `ADDR_CMD)
        begin
          s_d.cmd = par_wdata;
          s_d.mode_tag = active_operating_mode;
          s_d.rst_pulse = par_wdata[`CMD_FRST_BIT] & ~s_q.cmd[`CMD_FRST_BIT];
        end
        else if (par_addr == `ADDR_QSEL && qsel_legal(par_wdata))
          s_d.qsel = par_wdata;
        else
          s_d.err = 1'b1;
      end
      else
      begin
        s_d.rdata = rd[15:0];
        s_d.err = ~rd[16];
      end
    end
    // drive state machine
    if (any_fault && s_q.st != ST_FAULT_REACT && s_q.st != ST_FAULT)
    begin
      s_d.st = ST_FAULT_REACT;
      s_d.braking = 1'b1;
    end
    else
    begin
      unique case (s_q.st)
        ST_NOT_READY: s_d.st = ST_SW_DISABLED;
        ST_SW_DISABLED:
          if (c_shut)
            s_d.st = ST_READY;
        ST_READY:
          if (c_disv || c_qstp)
            s_d.st = ST_SW_DISABLED;
          else if (c_swon)
            s_d.st = ST_SWITCHED_ON;
        ST_SWITCHED_ON:
          if (c_disv || c_qstp)
            s_d.st = ST_SW_DISABLED;
          else if (c_shut)
            s_d.st = ST_READY;
          else if (c_enop)
            s_d.st = ST_OP_ENABLED;
        ST_OP_ENABLED:
          if (c_disv)
            s_d.st = ST_SW_DISABLED;
          else if (c_qstp)
          begin
            s_d.st = ST_QUICK_STOP;
            s_d.braking = 1'b1;
          end
          else if (c_shut)
            s_d.st = ST_READY;
          else if (c_swon)
            s_d.st = ST_SWITCHED_ON;
        ST_QUICK_STOP:
          if (s_q.braking && ramp_done)
          begin
            s_d.braking = 1'b0;
            if (qs_to_dis)
              s_d.st = ST_SW_DISABLED;
            if (s_q.qsel == `QS_PROF_INT || s_q.qsel == `QS_EMER_INT)
              s_d.integ_clr = 1'b1;
          end
          else if (!s_q.braking && c_disv)
            s_d.st = ST_SW_DISABLED;
          else if (!s_q.braking && c_enop)
            s_d.st = ST_OP_ENABLED;
        ST_FAULT_REACT:
          if (ramp_done)
          begin
            s_d.st = ST_FAULT;
            s_d.braking = 1'b0;
          end
        ST_FAULT:
          if (s_q.rst_pulse && !any_fault)
            s_d.st = ST_SW_DISABLED;
        default: s_d.st = ST_NOT_READY;
      endcase
    end
    s_d.status = state_code(s_d.st);
    s_d.speed_zero = (s_d.st == ST_QUICK_STOP) && (s_q.qsel == `QS_MAX);
    s_d.decel_sel = (s_d.st == ST_FAULT_REACT) || qs_emer;
    s_d.torque = (s_d.st == ST_OP_ENABLED) || (s_d.st == ST_QUICK_STOP) ||
                 (s_d.st == ST_FAULT_REACT) ||
                 ((s_d.st == ST_SWITCHED_ON) && standby_torque_select);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.st <= ST_NOT_READY;
      s_q.cmd <= `RST_CMD;
      s_q.qsel <= `RST_QSEL;
      s_q.status <= `SW_NOT_READY;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign par_rdata = s_q.rdata;
  assign par_ack = s_q.ack;
  assign par_err = s_q.err;
  assign status_word = s_q.status;
  assign torque_enable = s_q.torque;
  assign halt_request = s_q.cmd[`CMD_HALT_BIT];
  assign mode_cmd = s_q.cmd[`CMD_MODE_MSB:`CMD_MODE_LSB];
  assign mode_cmd_tag = s_q.mode_tag;
  assign gear_mode = s_q.cmd[`CMD_GEAR_MSB:`CMD_GEAR_LSB];
  assign ramp_active = s_q.braking;
  assign decel_select = s_q.decel_sel;
  assign speed_zero = s_q.speed_zero;
  assign velocity_integral_clear = s_q.integ_clr;
  assign fault_reset = s_q.rst_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ro_write_err_a: assert property (par_req && par_we && par_addr != `ADDR_CMD && par_addr != `ADDR_QSEL |=> par_ack && par_err) else $error("read-only word accepted a write");
  count_read_a: assert property (par_req && !par_we && par_addr == `ADDR_STO_COUNT |=> par_rdata == 16'h0002 && !par_err) else $error("wrong entry count");
  sto_read_a: assert property (par_req && !par_we && par_addr == `ADDR_STO_FAULT_LAT |=> par_rdata == $past(lat_w[2])) else $error("latched fault read wrong");
  int_read_a: assert property (par_req && !par_we && par_addr == `ADDR_INT_FAULT_LIVE |=> par_rdata == $past(live_w[3])) else $error("live fault read wrong");
  shutdown_step_a: assert property (!any_fault && s_q.st == ST_SW_DISABLED && par_req && par_we && par_addr == `ADDR_CMD && par_wdata == 16'h0006 ##1 !any_fault |=> s_q.st == ST_READY && status_word[6:5] == 2'b01 && status_word[3:0] == 4'h1) else $error("shutdown did not reach ready");
  halt_bit_a: assert property (par_req && par_we && par_addr == `ADDR_CMD |=> halt_request == $past(par_wdata[8]) && gear_mode == $past(par_wdata[15:13])) else $error("halt or gear bits not taken");
  status_op_a: assert property (s_q.st == ST_OP_ENABLED |-> status_word[6:5] == 2'b01 && status_word[3:0] == 4'h7) else $error("operation enabled encoding");
  status_qs_a: assert property (s_q.st == ST_QUICK_STOP |-> status_word[6:5] == 2'b00 && status_word[3:0] == 4'h7) else $error("quick stop encoding");
  status_fault_a: assert property (s_q.st == ST_FAULT |-> !status_word[6] && status_word[3:0] == 4'h8) else $error("fault encoding");
  disabled_code_a: assert property (s_q.st == ST_SW_DISABLED |-> status_word[6] && status_word[3:0] == 4'h0) else $error("disabled encoding");
  qs_max_a: assert property (s_q.st == ST_QUICK_STOP && s_q.qsel == `QS_MAX |-> speed_zero && decel_select) else $error("max stop without zero speed");
  integ_clear_a: assert property (s_q.st == ST_QUICK_STOP && s_q.braking && ramp_done && !any_fault && s_q.qsel == `QS_PROF_INT |=> velocity_integral_clear ##1 !velocity_integral_clear) else $error("integrator clear missing");
  qs_disable_a: assert property (s_q.st == ST_QUICK_STOP && s_q.braking && ramp_done && !any_fault && s_q.qsel == `QS_EMER_DIS |=> s_q.st == ST_SW_DISABLED) else $error("selector 2 did not disable");
  qs_stay_a: assert property (s_q.st == ST_QUICK_STOP && s_q.braking && ramp_done && !any_fault && s_q.qsel == `QS_PROF_STAY |=> s_q.st == ST_QUICK_STOP && !ramp_active && !decel_select) else $error("selector 5 left quick stop");
  standby_torque_a: assert property (s_q.st == ST_SWITCHED_ON |-> torque_enable == $past(standby_torque_select)) else $error("standby torque mismatch");

  op_reach_c: cover property (s_q.st == ST_SWITCHED_ON ##[1:20] s_q.st == ST_OP_ENABLED);
  qs_ramp_c: cover property (s_q.st == ST_QUICK_STOP && s_q.braking && ramp_done);
  fault_clear_c: cover property (s_q.st == ST_FAULT ##[1:20] s_q.st == ST_SW_DISABLED);

endmodule : drive_state_error_registers

// >>> param_master_model.sv
/*
  Parameter master model: issues single reads and writes on the parameter
  port of the drive bank, one request pulse per access.
  Assumes the bank registers its answer on the edge that takes the request.
*/
module param_master_model
(
  // clock
  input wire logic mclk,
  // request side
  output logic par_req,
  output logic par_we,
  output logic [15:0] par_addr,
  output logic [15:0] par_wdata,
  // answer side
  input wire logic [15:0] par_rdata,
  input wire logic par_ack,
  input wire logic par_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    par_req = 1'b0;
    par_we = 1'b0;
    par_addr = 16'h0000;
    par_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////
  // one access; released lines carry inverted garbage
  task automatic access(input logic we, input logic [15:0] addr,
    input logic [15:0] wdata, output logic [15:0] rdata,
    output logic ack, output logic err);
    @(posedge mclk);
    par_req <= 1'b1;
    par_we <= we;
    par_addr <= addr;
    par_wdata <= wdata;
    @(posedge mclk);
    par_req <= 1'b0;
    par_we <= ~we;
    par_addr <= ~addr;
    par_wdata <= ~wdata;
    #1;
    rdata = par_rdata;
    ack = par_ack;
    err = par_err;
  endtask : access
endmodule : param_master_model

// >>> drive_state_error_registers_tb.sv
/*
  Self-checking bench of the drive state and error parameter bank.
  Assumes the master model issues reads and writes and that the bench
  plays motion control and the error sources.
*/
`include "drive_regs_consts.svh"

module drive_state_error_registers_tb
  import drive_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic par_req, par_we, par_ack, par_err;
  logic [15:0] par_addr, par_wdata, par_rdata;
  logic [15:0] fb_warn_cond = 16'h0000;
  logic [15:0] fb_fault_cond = 16'h0000;
  logic [15:0] sto_fault_cond = 16'h0000;
  logic [15:0] int_fault_cond = 16'h0000;
  logic ramp_done = 1'b0;
  logic [7:0] active_operating_mode = 8'h00;
  logic standby_torque_select = 1'b0;
  logic [15:0] status_word;
  logic torque_enable, halt_request, ramp_active, decel_select;
  logic speed_zero, velocity_integral_clear, fault_reset;
  logic [2:0] mode_cmd, gear_mode;
  logic [7:0] mode_cmd_tag;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_iclr = 0;
  int n_frst = 0;

  always #10 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (velocity_integral_clear === 1'b1)
      n_iclr <= n_iclr + 1;
    if (fault_reset === 1'b1)
      n_frst <= n_frst + 1;
  end

  param_master_model u_master (.mclk(mclk), .par_req(par_req),
    .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata),
    .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err));

  drive_state_error_registers u_dut (.mclk(mclk), .resetn(resetn),
    .par_req(par_req), .par_we(par_we), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_err(par_err), .fb_warn_cond(fb_warn_cond),
    .fb_fault_cond(fb_fault_cond), .sto_fault_cond(sto_fault_cond),
    .int_fault_cond(int_fault_cond), .ramp_done(ramp_done),
    .active_operating_mode(active_operating_mode),
    .standby_torque_select(standby_torque_select),
    .status_word(status_word), .torque_enable(torque_enable),
    .halt_request(halt_request), .mode_cmd(mode_cmd),
    .mode_cmd_tag(mode_cmd_tag), .gear_mode(gear_mode),
    .ramp_active(ramp_active), .decel_select(decel_select),
    .speed_zero(speed_zero),
    .velocity_integral_clear(velocity_integral_clear),
    .fault_reset(fault_reset));

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp,
    input logic exp_err);
    logic [15:0] d;
    logic a;
    logic e;
    u_master.access(1'b0, addr, 16'h0000, d, a, e);
    check(16'(a), 16'h0001);
    check(16'(e), 16'(exp_err));
    check(d, exp);
  endtask : rd

  task automatic wr(input logic [15:0] addr, input logic [15:0] data,
    input logic exp_err);
    logic [15:0] d;
    logic a;
    logic e;
    u_master.access(1'b1, addr, data, d, a, e);
    check(16'(a), 16'h0001);
    check(16'(e), 16'(exp_err));
  endtask : wr

  // command write, then status seen one edge after the answer
  task automatic cmd(input logic [15:0] v, input logic [15:0] exp_st);
    wr(`ADDR_CMD, v, 1'b0);
    @(posedge mclk);
    #1;
    check(status_word, exp_st);
  endtask : cmd

  task automatic go_op();
    cmd(16'h0006, `SW_READY);
    cmd(16'h0007, `SW_ON);
    cmd(16'h000F, `SW_OP);
  endtask : go_op

  ////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [15:0] det [8] = '{`ADDR_FB_WARN_LAT, `ADDR_FB_WARN_LIVE,
      `ADDR_FB_FAULT_LAT, `ADDR_FB_FAULT_LIVE, `ADDR_STO_FAULT_LAT,
      `ADDR_STO_FAULT_LIVE, `ADDR_INT_FAULT_LAT, `ADDR_INT_FAULT_LIVE};
    foreach (det[i])
      rd(det[i], `RST_DETAIL, 1'b0);
    rd(`ADDR_FB_COUNT, {8'h00, `CNT_FB}, 1'b0);
    rd(`ADDR_STO_COUNT, {8'h00, `CNT_STO}, 1'b0);
    rd(`ADDR_INT_COUNT, {8'h00, `CNT_INT}, 1'b0);
    rd(`ADDR_QSEL, `RST_QSEL, 1'b0);
    rd(`ADDR_STATUS, `SW_DISABLED, 1'b0);
    rd(16'h0851, 16'h0000, 1'b1);
    wr(`ADDR_FB_FAULT_LAT, 16'h1234, 1'b1);
    wr(`ADDR_STO_FAULT_LIVE, 16'h00FF, 1'b1);
    wr(`ADDR_STATUS, 16'h0027, 1'b1);
    wr(`ADDR_FB_COUNT, 16'h0007, 1'b1);
    rd(`ADDR_FB_FAULT_LAT, `RST_DETAIL, 1'b0);
    rd(`ADDR_FB_COUNT, {8'h00, `CNT_FB}, 1'b0);
  endtask : t_reset_values

  task automatic t_commands();
    cmd(16'h0006, `SW_READY);
    cmd(16'h0007, `SW_ON);
    check(16'(torque_enable), 16'h0000);
    @(posedge mclk);
    standby_torque_select <= 1'b1;
    active_operating_mode <= 8'h03;
    repeat (2) @(posedge mclk);
    #1;
    check(16'(torque_enable), 16'h0001);
    cmd(16'hBF7F, `SW_OP);
    check(16'(halt_request), 16'h0001);
    check(16'(mode_cmd), 16'h0007);
    check(16'(gear_mode), 16'h0005);
    check(16'(mode_cmd_tag), 16'h0003);
    rd(`ADDR_CMD, 16'hBF7F, 1'b0);
    rd(`ADDR_STATUS, `SW_OP, 1'b0);
    wr(`ADDR_QSEL, 16'h0003, 1'b1);
    rd(`ADDR_QSEL, `RST_QSEL, 1'b0);
    cmd(16'h0000, `SW_DISABLED);
    check(16'(halt_request), 16'h0000);
    go_op();
    cmd(16'h0007, `SW_ON);
    cmd(16'h0006, `SW_READY);
    cmd(16'h0002, `SW_DISABLED);
  endtask : t_commands

  task automatic t_quick_stop();
    logic [15:0] sel [7] = '{`QS_MAX, `QS_PROF_INT, `QS_EMER_INT,
      `QS_PROF_DIS, `QS_EMER_DIS, `QS_PROF_STAY, `QS_EMER_STAY};
    int n0;
    for (int i = 0; i < 7; i++)
    begin
      go_op();
      wr(`ADDR_QSEL, sel[i], 1'b0);
      cmd(16'h0002, `SW_QSTOP);
      check(16'(ramp_active), 16'h0001);
      check(16'(decel_select), 16'(!(i == 1 || i == 3 || i == 5)));
      check(16'(speed_zero), 16'(i == 0));
      n0 = n_iclr;
      @(posedge mclk);
      ramp_done <= 1'b1;
      @(posedge mclk);
      ramp_done <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      check(status_word, (i == 0 || i == 3 || i == 4) ?
        `SW_DISABLED : `SW_QSTOP);
      check(16'(ramp_active), 16'h0000);
      check(16'(n_iclr - n0), 16'(i == 1 || i == 2));
      if (i == 1 || i == 2 || i > 4)
        cmd(16'h000F, `SW_OP);
      cmd(16'h0000, `SW_DISABLED);
    end
  endtask : t_quick_stop

  task automatic t_faults();
    logic [15:0] v [4] = '{16'h0101, 16'h0202, 16'h0404, 16'h8008};
    logic [15:0] lat [4] = '{`ADDR_FB_WARN_LAT, `ADDR_FB_FAULT_LAT,
      `ADDR_STO_FAULT_LAT, `ADDR_INT_FAULT_LAT};
    logic [15:0] live [4] = '{`ADDR_FB_WARN_LIVE, `ADDR_FB_FAULT_LIVE,
      `ADDR_STO_FAULT_LIVE, `ADDR_INT_FAULT_LIVE};
    int n0;
    @(posedge mclk);
    fb_warn_cond <= v[0];
    fb_fault_cond <= v[1];
    sto_fault_cond <= v[2];
    int_fault_cond <= v[3];
    repeat (4) @(posedge mclk);
    #1;
    check(status_word, `SW_FREACT);
    check(16'(ramp_active), 16'h0001);
    foreach (v[i])
      rd(live[i], v[i], 1'b0);
    @(posedge mclk);
    ramp_done <= 1'b1;
    fb_warn_cond <= 16'h0000;
    fb_fault_cond <= 16'h0000;
    sto_fault_cond <= 16'h0000;
    int_fault_cond <= 16'h0000;
    @(posedge mclk);
    ramp_done <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(status_word, `SW_FAULT);
    foreach (v[i])
    begin
      rd(lat[i], v[i], 1'b0);
      rd(live[i], 16'h0000, 1'b0);
    end
    cmd(16'h0000, `SW_FAULT);
    n0 = n_frst;
    wr(`ADDR_CMD, 16'h0080, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    check(16'(n_frst - n0), 16'h0001);
    check(status_word, `SW_DISABLED);
    foreach (v[i])
      rd(lat[i], `RST_DETAIL, 1'b0);
  endtask : t_faults

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    check(status_word, `SW_NOT_READY);
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check(status_word, `SW_DISABLED);
    t_reset_values();
    t_commands();
    t_quick_stop();
    t_faults();
    stop_test();
  end
endmodule : drive_state_error_registers_tb
